// >>> verilog/oscr_pkg.sv
// package: constants and types for the oscillator control registers
package oscr_pkg;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [1:0] OSCR_ADDR_CTRL = 2'h0;
    localparam logic [1:0] OSCR_ADDR_DIV  = 2'h1;
    localparam logic [1:0] OSCR_ADDR_TRIM = 2'h2;

    localparam logic [7:0] OSCR_KEY_HI_A = 8'h78;
    localparam logic [7:0] OSCR_KEY_HI_B = 8'h9a;
    localparam logic [7:0] OSCR_KEY_LO_A = 8'h46;
    localparam logic [7:0] OSCR_KEY_LO_B = 8'h57;

    localparam logic [2:0] OSCR_SRC_FRC      = 3'h0;
    localparam logic [2:0] OSCR_SRC_FRC_PLL  = 3'h1;
    localparam logic [2:0] OSCR_SRC_PRI      = 3'h2;
    localparam logic [2:0] OSCR_SRC_PRI_PLL  = 3'h3;
    localparam logic [2:0] OSCR_SRC_SEC      = 3'h4;
    localparam logic [2:0] OSCR_SRC_LOW_POWER_RC_OSC     = 3'h5;
    localparam logic [2:0] OSCR_SRC_RESERVED = 3'h6;
    localparam logic [2:0] OSCR_SRC_FRC_DIV  = 3'h7;

    localparam logic [15:0] OSCR_DIV_RESET  = 16'h0100;
    localparam logic [5:0]  OSCR_TRIM_RESET = 6'h00;

    // cycles of the new clock counted before changeover
    localparam int          OSCR_SETTLE_CYCLES = 10;
    localparam logic [3:0]  OSCR_SETTLE_LAST   =
        4'(OSCR_SETTLE_CYCLES - 1);

    typedef struct packed {
        logic [1:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } oscr_bus_t;

    typedef enum logic [1:0] {
        OSCR_IDLE,
        OSCR_WAIT_READY,
        OSCR_SETTLE
    } oscr_state_t;

endpackage

// >>> verilog/oscr_regs.sv
// module: oscillator control, divider and trim registers
module oscr_regs
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [1:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic [2:0]        initial_source_cfg,
    input  wire logic              switch_monitor_cfg,
    input  wire logic              one_way_pin_lock_cfg,
    input  wire logic              new_source_ready,
    input  wire logic              new_clock_tick,
    input  wire logic              pll_locked,
    input  wire logic              failsafe_monitor_fail,
    input  wire logic              irq_event,
    output logic      [2:0]        current_source_sel,
    output logic      [2:0]        target_source,
    output logic                   pin_map_lock,
    output logic                   primary_sleep_keep,
    output logic                   secondary_osc_on,
    output logic      [7:0]        periph_ratio,
    output logic      [8:0]        rc_divisor,
    output logic signed [5:0]      rc_trim
);

    // ------------------------------------------------------------
    // assertion clock
    // ------------------------------------------------------------
    default clocking oscr_cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    oscr_pkg::oscr_bus_t bus;
    assign bus = '{reg_addr, reg_wdata, reg_wr, reg_rd};

    wire wr_ctrl = bus.wr && bus.addr == oscr_pkg::OSCR_ADDR_CTRL;
    wire wr_div  = bus.wr && bus.addr == oscr_pkg::OSCR_ADDR_DIV;
    wire wr_trim = bus.wr && bus.addr == oscr_pkg::OSCR_ADDR_TRIM;
    wire [7:0] wr_hi = bus.wdata[15:8];
    wire [7:0] wr_lo = bus.wdata[7:0];

    // ------------------------------------------------------------
    // unlock sequences
    // ------------------------------------------------------------
    // stage: 0 idle, 1 first key seen, 2 unlocked for one write
    logic [1:0] hi_key_q;
    logic [1:0] hi_key_d;
    logic [1:0] lo_key_q;
    logic [1:0] lo_key_d;

    wire hi_open = hi_key_q == 2'h2;
    wire lo_open = lo_key_q == 2'h2;

    // any write breaks a partial sequence; only the next write is open
    always_comb
    begin
        hi_key_d = hi_key_q;
        lo_key_d = lo_key_q;
        if (bus.wr)
        begin
            hi_key_d = 2'h0;
            lo_key_d = 2'h0;
            if (wr_ctrl && hi_key_q == 2'h0
                && wr_hi == oscr_pkg::OSCR_KEY_HI_A)
            begin
                hi_key_d = 2'h1;
            end
            else if (wr_ctrl && hi_key_q == 2'h1
                     && wr_hi == oscr_pkg::OSCR_KEY_HI_B)
            begin
                hi_key_d = 2'h2;
            end
            if (wr_ctrl && lo_key_q == 2'h0
                && wr_lo == oscr_pkg::OSCR_KEY_LO_A)
            begin
                lo_key_d = 2'h1;
            end
            else if (wr_ctrl && lo_key_q == 2'h1
                     && wr_lo == oscr_pkg::OSCR_KEY_LO_B)
            begin
                lo_key_d = 2'h2;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hi_key_q <= 2'h0;
            lo_key_q <= 2'h0;
        end
        else
        begin
            hi_key_q <= hi_key_d;
            lo_key_q <= lo_key_d;
        end
    end

    wire hi_write = wr_ctrl && hi_open;
    wire lo_write = wr_ctrl && lo_open;

    // ------------------------------------------------------------
    // control register state
    // ------------------------------------------------------------
    logic [2:0] cur_q;
    logic [2:0] req_q;
    logic       start_q;
    logic       src_lock_q;
    logic       pin_lock_q;
    logic       fail_q;
    logic       keep_q;
    logic       sec_q;
    logic       strap_q;
    oscr_pkg::oscr_state_t state_q;
    logic [3:0] settle_q;

    // switching is allowed only when the configuration bit is low
    wire sw_enabled = !switch_monitor_cfg;
    wire locked_sel = src_lock_q && sw_enabled;
    wire start_req  = lo_write && wr_lo[0] && sw_enabled && !locked_sel;
    wire redundant  = req_q == cur_q;
    wire begin_sw   = state_q == oscr_pkg::OSCR_IDLE && start_q && !redundant;
    wire finish_sw  = state_q == oscr_pkg::OSCR_SETTLE && new_clock_tick
                      && settle_q == oscr_pkg::OSCR_SETTLE_LAST;
    wire cur_pll    = cur_q == oscr_pkg::OSCR_SRC_FRC_PLL
                      || cur_q == oscr_pkg::OSCR_SRC_PRI_PLL;
    wire switching  = state_q != oscr_pkg::OSCR_IDLE;
    wire pll_status = pll_locked && cur_pll && !switching;

    // ------------------------------------------------------------
    // switch sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q  <= oscr_pkg::OSCR_IDLE;
            settle_q <= 4'h0;
        end
        else
        begin
            unique case (state_q)
                oscr_pkg::OSCR_IDLE:
                    if (begin_sw)
                    begin
                        state_q <= oscr_pkg::OSCR_WAIT_READY;
                    end
                oscr_pkg::OSCR_WAIT_READY:
                    if (new_source_ready)
                    begin
                        state_q  <= oscr_pkg::OSCR_SETTLE;
                        settle_q <= 4'h0;
                    end
                oscr_pkg::OSCR_SETTLE:
                    if (finish_sw)
                    begin
                        state_q <= oscr_pkg::OSCR_IDLE;
                    end
                    else if (new_clock_tick)
                    begin
                        settle_q <= settle_q + 4'h1;
                    end
            endcase
        end
    end

    // configuration strap captured on the first clock after reset
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            strap_q <= 1'b1;
        end
        else
        begin
            strap_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cur_q      <= oscr_pkg::OSCR_SRC_FRC_DIV;
            req_q      <= oscr_pkg::OSCR_SRC_FRC_DIV;
            start_q    <= 1'b0;
            src_lock_q <= 1'b0;
            pin_lock_q <= 1'b0;
            fail_q     <= 1'b0;
            keep_q     <= 1'b0;
            sec_q      <= 1'b0;
        end
        else
        begin
            if (strap_q)
            begin
                cur_q <= initial_source_cfg;
                req_q <= initial_source_cfg;
            end
            else if (finish_sw)
            begin
                cur_q <= req_q;
            end
            if (!strap_q && hi_write && sw_enabled && !locked_sel && !switching
                && wr_hi[2:0] != oscr_pkg::OSCR_SRC_RESERVED)
            begin
                req_q <= wr_hi[2:0];
            end
            if (!sw_enabled || finish_sw
                || (start_q && redundant && !switching))
            begin
                start_q <= 1'b0;
            end
            else if (start_req)
            begin
                start_q <= 1'b1;
            end
            if (lo_write && wr_lo[7])
            begin
                src_lock_q <= 1'b1;
            end
            if (lo_write && !(one_way_pin_lock_cfg && pin_lock_q))
            begin
                pin_lock_q <= wr_lo[6];
            end
            if (failsafe_monitor_fail)
            begin
                fail_q <= 1'b1;
            end
            else if (begin_sw || (lo_write && !wr_lo[3]))
            begin
                fail_q <= 1'b0;
            end
            if (lo_write)
            begin
                keep_q <= wr_lo[2];
                sec_q  <= wr_lo[1];
            end
        end
    end

    // ------------------------------------------------------------
    // divider and trim registers
    // ------------------------------------------------------------
    logic [7:0] div_q;
    logic [5:0] trim_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_q  <= oscr_pkg::OSCR_DIV_RESET[15:8];
            trim_q <= oscr_pkg::OSCR_TRIM_RESET;
        end
        else
        begin
            if (wr_div)
            begin
                div_q <= wr_hi;
            end
            if (irq_event && div_q[7] && !(wr_div && !wr_hi[7]))
            begin
                div_q[3] <= 1'b0;
            end
            if (wr_trim)
            begin
                trim_q <= wr_lo[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire [2:0] ratio_code = div_q[3] ? div_q[6:4] : 3'h0;
    assign periph_ratio       = 8'h01 << ratio_code;
    // code 7 skips divide by 128 and jumps to 256
    wire [3:0] post_shift = div_q[2:0] == 3'h7 ? 4'h8 : {1'b0, div_q[2:0]};
    assign rc_divisor         = 9'h001 << post_shift;
    assign rc_trim            = signed'(trim_q);
    assign current_source_sel = cur_q;
    assign target_source      = req_q;
    assign pin_map_lock       = pin_lock_q;
    assign primary_sleep_keep = keep_q;
    assign secondary_osc_on   = sec_q;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] ctrl_word = {1'b0, cur_q, 1'b0, req_q, src_lock_q,
                             pin_lock_q, pll_status, 1'b0, fail_q,
                             keep_q, sec_q, start_q};
    wire [15:0] rd_word =
        bus.addr == oscr_pkg::OSCR_ADDR_CTRL ? ctrl_word :
        bus.addr == oscr_pkg::OSCR_ADDR_DIV  ? {div_q, 8'h00} :
        bus.addr == oscr_pkg::OSCR_ADDR_TRIM ? {10'h000, trim_q} :
        16'h0000;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            reg_rdata <= bus.rd ? rd_word : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_settle_end;
        state_q == oscr_pkg::OSCR_SETTLE && new_clock_tick
        && settle_q == oscr_pkg::OSCR_SETTLE_LAST;
    endsequence

    a_switch_copy: assert property (
        s_settle_end |=> cur_q == $past(req_q) && !start_q)
        else $error("switch completion did not copy source");
    a_redundant_abort: assert property (
        (state_q == oscr_pkg::OSCR_IDLE && start_q && redundant) |=> !start_q)
        else $error("redundant switch not abandoned");
    a_pll_status_zero: assert property (
        (bus.rd && bus.addr == oscr_pkg::OSCR_ADDR_CTRL
         && (switching || !cur_pll)) |=> !reg_rdata[5])
        else $error("pll status read high during switch or non-pll mode");
    a_fail_sticky: assert property (
        failsafe_monitor_fail |=> fail_q)
        else $error("clock fail flag not set");
    a_fail_no_set: assert property (
        (!fail_q && !failsafe_monitor_fail) |=> !fail_q)
        else $error("clock fail flag set without failure");
    a_lock_blocks: assert property (
        (locked_sel && !start_q) |=> !start_q)
        else $error("switch started while selection locked");
    a_no_switch_cfg: assert property (
        switch_monitor_cfg |=> !start_q)
        else $error("switch start held while switching disabled");
    a_pin_one_way: assert property (
        (one_way_pin_lock_cfg && pin_lock_q) |=> pin_lock_q)
        else $error("one-way pin lock cleared");
    a_no_unlock_hold: assert property (
        (wr_ctrl && !lo_open && !failsafe_monitor_fail) |=> $stable(keep_q)
        && $stable(sec_q))
        else $error("locked low byte changed without unlock");
    a_recover_irq: assert property (
        (irq_event && div_q[7] && !wr_div) |=> periph_ratio == 8'h01)
        else $error("interrupt did not restore ratio");
    a_settle_count: assert property (
        (state_q == oscr_pkg::OSCR_WAIT_READY && new_source_ready)
        |=> !finish_sw [*1] ##0 settle_q == 4'h0)
        else $error("settle count not restarted");
    a_unimpl_zero: assert property (
        bus.rd |=> ($past(bus.addr) != oscr_pkg::OSCR_ADDR_CTRL
                    || (reg_rdata & 16'h8810) == 16'h0000)
               && ($past(bus.addr) != oscr_pkg::OSCR_ADDR_DIV
                    || reg_rdata[7:0] == 8'h00)
               && ($past(bus.addr) != oscr_pkg::OSCR_ADDR_TRIM
                    || reg_rdata[15:6] == 10'h000))
        else $error("unimplemented bits read nonzero");
    a_divisor_top: assert property (
        div_q[2:0] == 3'h7 |-> rc_divisor == 9'h100)
        else $error("top postscaler code not divide by 256");
    a_lock_set_only: assert property (
        src_lock_q |=> src_lock_q)
        else $error("source lock cleared");
    a_pin_needs_unlock: assert property (
        !lo_write |=> $stable(pin_lock_q))
        else $error("pin lock changed without unlock");
    a_reserved_refused: assert property (
        (hi_write && !strap_q && wr_hi[2:0] == oscr_pkg::OSCR_SRC_RESERVED)
        |=> $stable(req_q))
        else $error("reserved source code accepted");

endmodule // oscr_regs

// >>> dv/test_oscillator_control_registers.sv
// testbench: self-checking run of the oscillator control registers
module test_oscillator_control_registers;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_sys;
    logic              reset;
    logic [1:0]        reg_addr;
    logic [15:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [15:0]       reg_rdata;
    logic [2:0]        initial_source_cfg;
    logic              switch_monitor_cfg;
    logic              one_way_pin_lock_cfg;
    logic              new_source_ready;
    logic              new_clock_tick;
    logic              pll_locked;
    logic              failsafe_monitor_fail;
    logic              irq_event;
    logic [2:0]        current_source_sel;
    logic [2:0]        target_source;
    logic              pin_map_lock;
    logic              primary_sleep_keep;
    logic              secondary_osc_on;
    logic [7:0]        periph_ratio;
    logic [8:0]        rc_divisor;
    logic signed [5:0] rc_trim;
    logic [15:0]       v;
    logic [15:0]       r;
    logic [15:0]       d;
    logic [15:0]       e;
    logic [5:0]        t;
    int                num_errors;
    int                cmp_count;

    oscr_regs dut
    (
        .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .initial_source_cfg, .switch_monitor_cfg,
        .one_way_pin_lock_cfg, .new_source_ready, .new_clock_tick,
        .pll_locked, .failsafe_monitor_fail, .irq_event,
        .current_source_sel, .target_source, .pin_map_lock,
        .primary_sleep_keep, .secondary_osc_on, .periph_ratio,
        .rc_divisor, .rc_trim
    );

    // ------------------------------------------------------------
    // expectations, bus tasks and reporting
    // ------------------------------------------------------------
    function automatic logic [7:0] ratio_exp(logic apply, logic [2:0] c);
        return apply ? (8'h01 << c) : 8'h01;
    endfunction

    function automatic logic [8:0] divisor_exp(logic [2:0] c);
        return (c == 3'h7) ? 9'h100 : (9'h001 << c);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write strobe is left high so writes can run back to back
    task automatic wr(input logic [1:0] a, input logic [15:0] dat);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= dat;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk_sys);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
    endtask

    // keyed control write: hi selects the high-byte key pair
    task automatic ul(input logic hi, input logic [15:0] dat);
        wr(2'h0, hi ? 16'h7800 : 16'h0046);
        wr(2'h0, hi ? 16'h9a00 : 16'h0057);
        wr(2'h0, dat);
        idle(2);
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            new_clock_tick <= 1'b1;
            @(posedge clk_sys);
            new_clock_tick <= 1'b0;
        end
    endtask

    task automatic do_reset(input logic [2:0] strap);
        @(posedge clk_sys);
        reset              <= 1'b1;
        initial_source_cfg <= strap;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        idle(2);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        reset = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        initial_source_cfg = 3'h7;
        switch_monitor_cfg = 1'b0;
        one_way_pin_lock_cfg = 1'b1;
        new_source_ready = 1'b0;
        new_clock_tick = 1'b0;
        pll_locked = 1'b1;
        failsafe_monitor_fail = 1'b0;
        irq_event = 1'b0;
        void'($urandom(32'h26cfcabc));
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        idle(2);
        rd(2'h0);
        chk(v, 16'h7700);
        rd(2'h1);
        chk(v, 16'h0100);
        rd(2'h2);
        chk(v, 16'h0000);
        rd(2'h3);
        chk(v, 16'h0000);
        $display("test reset values done");
        pll_locked <= 1'b0;
        wr(2'h0, 16'h0200);
        idle(1);
        rd(2'h0);
        chk(v, 16'h7700);
        ul(1'b1, 16'h0600);
        rd(2'h0);
        chk(v, 16'h7700);
        ul(1'b1, 16'h0300);
        rd(2'h0);
        chk(v, 16'h7300);
        chk({13'h0, target_source}, 16'h0003);
        $display("test requested source done");
        pll_locked <= 1'b1;
        ul(1'b0, 16'h0001);
        idle(2);
        rd(2'h0);
        chk(v, 16'h7301);
        new_source_ready <= 1'b1;
        ticks(9);
        rd(2'h0);
        chk({13'h0, v[14:12]}, 16'h0007);
        ticks(1);
        idle(3);
        rd(2'h0);
        chk(v, 16'h3320);
        chk({13'h0, current_source_sel}, 16'h0003);
        pll_locked <= 1'b0;
        idle(2);
        rd(2'h0);
        chk(v, 16'h3300);
        ul(1'b0, 16'h0001);
        idle(2);
        rd(2'h0);
        chk(v, 16'h3300);
        $display("test switching done");
        for (int i = 0; i < 4; i++)
        begin
            ul(1'b0, 16'(i << 1));
            chk({15'h0, primary_sleep_keep}, 16'(i >> 1));
            chk({15'h0, secondary_osc_on}, 16'(i & 1));
        end
        @(posedge clk_sys);
        failsafe_monitor_fail <= 1'b1;
        @(posedge clk_sys);
        failsafe_monitor_fail <= 1'b0;
        rd(2'h0);
        chk({15'h0, v[3]}, 16'h0001);
        ul(1'b0, 16'h0000);
        rd(2'h0);
        chk({15'h0, v[3]}, 16'h0000);
        ul(1'b0, 16'h0008);
        rd(2'h0);
        chk({15'h0, v[3]}, 16'h0000);
        $display("test status bits done");
        wr(2'h0, 16'h0040);
        idle(2);
        chk({15'h0, pin_map_lock}, 16'h0000);
        ul(1'b0, 16'h0040);
        chk({15'h0, pin_map_lock}, 16'h0001);
        ul(1'b0, 16'h0000);
        chk({15'h0, pin_map_lock}, 16'h0001);
        one_way_pin_lock_cfg <= 1'b0;
        ul(1'b0, 16'h0000);
        chk({15'h0, pin_map_lock}, 16'h0000);
        ul(1'b0, 16'h0080);
        ul(1'b1, 16'h0000);
        ul(1'b0, 16'h0000);
        rd(2'h0);
        chk(v, 16'h3380);
        switch_monitor_cfg <= 1'b1;
        ul(1'b0, 16'h0001);
        rd(2'h0);
        chk({15'h0, v[0]}, 16'h0000);
        $display("test locks done");
        pll_locked <= 1'b1;
        switch_monitor_cfg <= 1'b0;
        do_reset(3'h2);
        rd(2'h0);
        chk(v, 16'h2200);
        for (int i = 0; i < 8; i++)
        begin
            r = 16'($urandom);
            d = {r[15], 3'(i), r[11], 3'(i), r[7:0]};
            wr(2'h1, d);
            rd(2'h1);
            chk(v, d & 16'hff00);
            e = {8'h0, ratio_exp(r[11], 3'(i))};
            chk({8'h0, periph_ratio}, e);
            chk({7'h0, rc_divisor}, {7'h0, divisor_exp(3'(i))});
        end
        for (int k = 0; k < 2; k++)
        begin
            d = k ? 16'h3b00 : 16'hbb00;
            wr(2'h1, d);
            idle(1);
            irq_event <= 1'b1;
            idle(1);
            irq_event <= 1'b0;
            rd(2'h1);
            chk(v, k ? 16'h3b00 : 16'hb300);
            chk({8'h0, periph_ratio}, k ? 16'h0008 : 16'h0001);
        end
        for (int i = 0; i < 5; i++)
        begin
            r = 16'($urandom);
            t = (i < 4) ? 6'(32'h3f201f00 >> (8 * i)) : r[5:0];
            wr(2'h2, {r[15:6], t});
            rd(2'h2);
            chk(v, {10'h0, t});
            chk({10'h0, rc_trim}, {10'h0, t});
            chk({15'h0, rc_trim < 0}, {15'h0, t[5]});
        end
        $display("test divider and trim done");
        wrap_up();
    end
endmodule // test_oscillator_control_registers
